//--- hdl/rsc_pkg.sv
// Purpose: Constants, types and register layout of the reset source combiner.
// Assumes: 200 MHz system clock, one 16-bit status register on a plain port.
// Notes:   Long delay counts are module parameters so that simulation may shorten them.
package rsc_pkg;
    localparam int          ADDR_W          = 4;
    localparam int          DATA_W          = 16;
    localparam logic [3:0]  STATUS_ADDR      = 4'h0;
    localparam logic [15:0] STATUS_RESET     = 16'h0003;
    localparam logic [15:0] STATUS_IMPL_MASK = 16'hC3FF;
    localparam int          B_POR            = 0;
    localparam int          B_BROWNOUT       = 1;
    localparam int          B_IDLE           = 2;
    localparam int          B_SLEEP          = 3;
    localparam int          B_WDOG_TO        = 4;
    localparam int          B_WDOG_EN        = 5;
    localparam int          B_SOFT           = 6;
    localparam int          B_PIN            = 7;
    localparam int          B_VREG           = 8;
    localparam int          B_MISMATCH       = 9;
    localparam int          B_ILL            = 14;
    localparam int          B_TRAP           = 15;
    localparam logic [23:0] RESET_VECTOR     = 24'h000000;
    localparam int          CLK_PERIOD_NS    = 5;
    localparam int          OST_TICKS        = 1024;
    localparam int          HOLD_STEP_MS     = 2;
    localparam int          HOLD_STEP_CYC    = HOLD_STEP_MS * 1000000 / CLK_PERIOD_NS;
    localparam int          MON_DLY_US       = 900;
    localparam int          MON_DLY_CYC      = MON_DLY_US * 1000 / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        OSC_FAST_RC      = 3'h0,
        OSC_FAST_RC_PLL  = 3'h1,
        OSC_CRYSTAL      = 3'h2,
        OSC_FAST_CRYSTAL = 3'h3,
        OSC_EXT_CLOCK    = 3'h4,
        OSC_CRYSTAL_PLL  = 3'h5,
        OSC_EXT_PLL      = 3'h6,
        OSC_LOW_POWER_RC = 3'h7
    } rsc_osc_e;

    typedef enum logic [4:0] {
        ST_HOLD = 5'h01,
        ST_PWRUP  = 5'h02,
        ST_OSC    = 5'h04,
        ST_MONDLY = 5'h08,
        ST_RUN  = 5'h10
    } rsc_state_e;

    typedef struct packed {
        logic por_active;
        logic brownout_active;
        logic master_clear_pin_n;
        logic soft_reset_req;
        logic watchdog_timeout;
        logic config_mismatch;
        logic trap_conflict;
        logic illegal_condition;
    } rsc_src_s;

    typedef struct packed {
        logic [2:0] initial_osc_select_fuse;
        logic [2:0] powerup_delay_select;
        logic       watchdog_fuse_enable;
        logic       clock_fail_monitor_en;
    } rsc_fuse_s;
endpackage

//--- hdl/reset_source_combiner.sv
// Purpose: Merge reset sources, record causes, sequence release and clock start.
// Assumes: All inputs synchronous to clk_i; detector inputs include their own delays.
// Notes:   Reset output is combinational so a source asserts it in the same cycle.
`timescale 1ns/1ps
module reset_source_combiner #(
    parameter int PWRUP_STEP_CYCLES = rsc_pkg::HOLD_STEP_CYC,
    parameter int MON_DLY_CYCLES    = rsc_pkg::MON_DLY_CYC
) (
    input  wire logic                       clk_i,
    input  wire logic                       srst_i,
    input  wire logic [rsc_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [rsc_pkg::DATA_W-1:0] wdata_i,
    input  wire logic                       wr_i,
    input  wire logic                       rd_i,
    output logic      [rsc_pkg::DATA_W-1:0] rdata_o,
    input  wire rsc_pkg::rsc_src_s          src_i,
    input  wire logic                       sleep_entered_i,
    input  wire logic                       idle_entered_i,
    input  wire rsc_pkg::rsc_fuse_s         fuse_i,
    input  wire logic [2:0]                 current_osc_field_i,
    input  wire logic                       osc_startup_done_i,
    input  wire logic                       osc_tick_i,
    input  wire logic                       pll_lock_i,
    output logic                            system_reset_out_o,
    output logic [2:0]                      osc_select_o,
    output logic                            osc_enable_o,
    output logic                            clock_ready_o,
    output logic                            cpu_run_o,
    output logic [23:0]                     fetch_addr_o,
    output logic                            monitor_enable_o,
    output logic                            watchdog_enable_o,
    output logic                            regulator_sleep_keep_o
);
    import rsc_pkg::*;

    logic [15:0] status_q;
    logic [15:0] status_d;
    logic [15:0] set_evt;
    logic [15:0] rdata_q;
    rsc_state_e  st_q;
    logic [31:0] cnt_q;
    logic [10:0] ost_q;
    logic        cold_q;
    logic [2:0]  osc_sel_q;
    logic [23:0] fetch_q;
    logic        src_any;
    logic        cold_src;
    logic        need_toscd;
    logic        need_ost;
    logic        need_lock;
    logic        osc_ready;
    logic        reg_wr;
    logic [31:0] pwrup_cycles;

    assign cold_src = src_i.por_active | src_i.brownout_active;
    assign src_any  = cold_src | ~src_i.master_clear_pin_n | src_i.soft_reset_req
                    | src_i.watchdog_timeout | src_i.config_mismatch
                    | src_i.trap_conflict | src_i.illegal_condition;

    // Asserts with the source, releases only from the sequencer state
    assign system_reset_out_o = src_any | (st_q == ST_HOLD) | (st_q == ST_PWRUP);

    // Cause flags
    always_comb begin
        set_evt          = '0;
        set_evt[B_POR]   = src_i.por_active;
        set_evt[B_BROWNOUT] = src_i.brownout_active;
        set_evt[B_IDLE]     = idle_entered_i;
        set_evt[B_SLEEP]    = sleep_entered_i;
        set_evt[B_WDOG_TO]  = src_i.watchdog_timeout;
        set_evt[B_SOFT]     = src_i.soft_reset_req;
        set_evt[B_PIN]      = ~src_i.master_clear_pin_n;
        set_evt[B_MISMATCH] = src_i.config_mismatch;
        set_evt[B_ILL]   = src_i.illegal_condition;
        set_evt[B_TRAP]  = src_i.trap_conflict;
    end

    assign reg_wr = wr_i && (addr_i == STATUS_ADDR);

    always_comb begin
        status_d = status_q;
        if (reg_wr) begin
            status_d = wdata_i & STATUS_IMPL_MASK;
        end
        // Hardware events beat a software clear in the same cycle
        status_d = status_d | set_evt;
        if (src_i.por_active) begin
            status_d = STATUS_RESET;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            status_q <= STATUS_RESET;
        end else begin
            status_q <= status_d;
        end
    end

    // Read data valid in the cycle after the strobe only
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_q <= '0;
        end else if (rd_i && addr_i == STATUS_ADDR) begin
            rdata_q <= status_q & STATUS_IMPL_MASK;
        end else begin
            rdata_q <= '0;
        end
    end
    assign rdata_o = rdata_q;

    assign watchdog_enable_o      = fuse_i.watchdog_fuse_enable | status_q[B_WDOG_EN];
    assign regulator_sleep_keep_o = status_q[B_VREG];

    // Power-up delay: 0, then doubling steps up to 128 ms at setting 7
    assign pwrup_cycles = (fuse_i.powerup_delay_select == 3'h0) ? 32'h0 :
        32'(PWRUP_STEP_CYCLES) << (fuse_i.powerup_delay_select - 3'h1);

    always_comb begin
        need_toscd = 1'b1;
        need_ost   = 1'b0;
        need_lock  = 1'b0;
        unique case (rsc_osc_e'(osc_sel_q))
            OSC_FAST_RC, OSC_LOW_POWER_RC: begin
            end
            OSC_FAST_RC_PLL: begin
                need_lock = 1'b1;
            end
            OSC_CRYSTAL, OSC_FAST_CRYSTAL: begin
                need_ost = 1'b1;
            end
            OSC_CRYSTAL_PLL: begin
                need_ost  = 1'b1;
                need_lock = 1'b1;
            end
            OSC_EXT_CLOCK: begin
                need_toscd = 1'b0;
            end
            OSC_EXT_PLL: begin
                need_toscd = 1'b0;
                need_lock  = 1'b1;
            end
        endcase
    end

    assign osc_ready = (osc_startup_done_i | ~need_toscd)
                     & ((ost_q == 11'(OST_TICKS)) | ~need_ost)
                     & (pll_lock_i | ~need_lock);

    // Start-up timer counts oscillator periods only while waiting
    always_ff @(posedge clk_i) begin
        if (srst_i || st_q != ST_OSC) begin
            ost_q <= '0;
        end else if (osc_tick_i && ost_q != 11'(OST_TICKS)) begin
            ost_q <= ost_q + 11'h001;
        end
    end

    // Cold reset remembered until the clock is running again
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cold_q <= 1'b1;
        end else if (cold_src) begin
            cold_q <= 1'b1;
        end else if (st_q == ST_RUN) begin
            cold_q <= 1'b0;
        end
    end

    // Release sequencer
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_q      <= ST_HOLD;
            cnt_q     <= '0;
            osc_sel_q <= OSC_FAST_RC;
        end else if (src_any) begin
            st_q <= ST_HOLD;
        end else begin
            unique case (st_q)
                ST_HOLD: begin
                    if (cold_q) begin
                        osc_sel_q <= fuse_i.initial_osc_select_fuse;
                        cnt_q     <= pwrup_cycles;
                        st_q      <= ST_PWRUP;
                    end else begin
                        // Clock kept running: ready at once
                        osc_sel_q <= current_osc_field_i;
                        cnt_q     <= 32'(MON_DLY_CYCLES);
                        st_q      <= ST_MONDLY;
                    end
                end
                ST_PWRUP: begin
                    if (cnt_q == 32'h0) begin
                        st_q <= ST_OSC;
                    end else begin
                        cnt_q <= cnt_q - 32'h1;
                    end
                end
                ST_OSC: begin
                    if (osc_ready) begin
                        cnt_q <= 32'(MON_DLY_CYCLES);
                        st_q  <= ST_MONDLY;
                    end
                end
                ST_MONDLY: begin
                    if (cnt_q == 32'h0) begin
                        st_q <= ST_RUN;
                    end else begin
                        cnt_q <= cnt_q - 32'h1;
                    end
                end
                ST_RUN: begin
                end
                default: begin
                    st_q <= ST_HOLD;
                end
            endcase
        end
    end

    // Fetch pointer forced to the vector while in reset
    always_ff @(posedge clk_i) begin
        if (srst_i || system_reset_out_o) begin
            fetch_q <= RESET_VECTOR;
        end else begin
            fetch_q <= fetch_q;
        end
    end

    assign osc_select_o     = osc_sel_q;
    assign osc_enable_o     = ~((st_q == ST_HOLD) & cold_q) & (st_q != ST_PWRUP);
    assign clock_ready_o    = (st_q == ST_MONDLY) | (st_q == ST_RUN);
    assign cpu_run_o        = clock_ready_o & ~src_any;
    assign fetch_addr_o     = fetch_q;
    // Monitor drops with a new source, before the state falls back to hold
    assign monitor_enable_o = (st_q == ST_RUN) & ~src_any & fuse_i.clock_fail_monitor_en;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    sequence s_cold_release;
        (st_q == ST_HOLD) && !src_any && cold_q;
    endsequence

    sequence s_warm_release;
        (st_q == ST_HOLD) && !src_any && !cold_q;
    endsequence

    property p_any_source_resets;
        src_any |-> system_reset_out_o;
    endproperty
    a_any_source_resets: assert property (p_any_source_resets)
        else $error("source active without system reset");

    property p_pin_flag;
        !src_i.master_clear_pin_n && !src_i.por_active |=> status_q[B_PIN];
    endproperty
    a_pin_flag: assert property (p_pin_flag)
        else $error("pin reset flag not set");

    property p_trap_flag;
        src_i.trap_conflict && !src_i.por_active |=> status_q[B_TRAP];
    endproperty
    a_trap_flag: assert property (p_trap_flag)
        else $error("trap conflict flag not set");

    property p_por_clears;
        src_i.por_active |=> status_q == STATUS_RESET;
    endproperty
    a_por_clears: assert property (p_por_clears)
        else $error("power-on did not restore status");

    property p_unimpl_zero;
        rdata_o[13:10] == 4'h0;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero)
        else $error("unimplemented bits read nonzero");

    property p_read_latency;
        rd_i && addr_i == STATUS_ADDR && !reg_wr |=> rdata_o == (($past(status_q)) & STATUS_IMPL_MASK);
    endproperty
    a_read_latency: assert property (p_read_latency)
        else $error("read data not from status register");

    property p_wdt_fuse;
        fuse_i.watchdog_fuse_enable |-> watchdog_enable_o;
    endproperty
    a_wdt_fuse: assert property (p_wdt_fuse)
        else $error("watchdog disabled against fuse");

    property p_warm_keeps_clock;
        s_warm_release |=> clock_ready_o && osc_select_o == $past(current_osc_field_i);
    endproperty
    a_warm_keeps_clock: assert property (p_warm_keeps_clock)
        else $error("warm reset changed clock");

    property p_cold_fuse_clock;
        s_cold_release |=> (st_q == ST_PWRUP) && system_reset_out_o
            && osc_select_o == $past(fuse_i.initial_osc_select_fuse);
    endproperty
    a_cold_fuse_clock: assert property (p_cold_fuse_clock)
        else $error("cold reset did not take fuse clock");

    property p_ost_full;
        (st_q == ST_OSC) && need_ost && !src_any |=> (st_q == ST_OSC) || (ost_q == 11'(OST_TICKS));
    endproperty
    a_ost_full: assert property (p_ost_full)
        else $error("crystal ready before start-up timer");

    property p_vector;
        $rose(cpu_run_o) |-> fetch_addr_o == RESET_VECTOR;
    endproperty
    a_vector: assert property (p_vector)
        else $error("core started away from reset vector");

    property p_monitor_after_ready;
        monitor_enable_o |-> clock_ready_o && !system_reset_out_o;
    endproperty
    a_monitor_after_ready: assert property (p_monitor_after_ready)
        else $error("monitor started before clock ready");

    property p_soft_flag;
        src_i.soft_reset_req && !src_i.por_active |=> status_q[B_SOFT];
    endproperty
    a_soft_flag: assert property (p_soft_flag)
        else $error("software reset flag not set");

    property p_wdog_flag;
        src_i.watchdog_timeout && !src_i.por_active |=> status_q[B_WDOG_TO];
    endproperty
    a_wdog_flag: assert property (p_wdog_flag)
        else $error("watchdog time-out flag not set");

    property p_mismatch_flag;
        src_i.config_mismatch && !src_i.por_active |=> status_q[B_MISMATCH];
    endproperty
    a_mismatch_flag: assert property (p_mismatch_flag)
        else $error("configuration mismatch flag not set");

    property p_illegal_flag;
        src_i.illegal_condition && !src_i.por_active |=> status_q[B_ILL];
    endproperty
    a_illegal_flag: assert property (p_illegal_flag)
        else $error("illegal condition flag not set");

    property p_sleep_flag;
        sleep_entered_i && !src_i.por_active |=> status_q[B_SLEEP];
    endproperty
    a_sleep_flag: assert property (p_sleep_flag)
        else $error("sleep flag not set");

    property p_idle_flag;
        idle_entered_i && !src_i.por_active |=> status_q[B_IDLE];
    endproperty
    a_idle_flag: assert property (p_idle_flag)
        else $error("idle flag not set");
endmodule // reset_source_combiner

//--- sim/rsc_osc_model.sv
// Purpose: Oscillator block model facing the reset source combiner.
// Assumes: Enable high means the selected source may run.
// Notes:   Start-up and lock are short counts so that runs stay brief.
`timescale 1ns/1ps
module rsc_osc_model #(
    parameter int STARTUP_CYC = 6,
    parameter int LOCK_CYC    = 20
) (
    input  wire logic       clk_i,
    input  wire logic       osc_enable_i,
    input  wire logic [2:0] osc_select_i,
    input  wire logic [2:0] running_sel_i,
    output logic            startup_done_o,
    output logic            tick_o,
    output logic            pll_lock_o,
    output logic [2:0]      current_osc_field_o
);
    int unsigned run_q;

    always_ff @(posedge clk_i) begin
        run_q <= osc_enable_i ? run_q + 1 : 0;
    end

    // Tick, start-up and lock drop when the oscillator is held off, never a stale level
    assign tick_o              = osc_enable_i && run_q[0];
    assign startup_done_o      = osc_enable_i && (run_q >= STARTUP_CYC);
    assign pll_lock_o          = osc_enable_i && (run_q >= LOCK_CYC)
                                 && (osc_select_i inside {3'h1, 3'h5, 3'h6});
    assign current_osc_field_o = running_sel_i;
endmodule // rsc_osc_model

//--- sim/test_reset_source_combiner.sv
// Purpose: Self-checking bench for the reset source combiner.
// Assumes: Short power-up and monitor counts set by parameter.
// Notes:   Oscillator side comes from the model; sources are driven here.
`timescale 1ns/1ps
module test_reset_source_combiner;
    import rsc_pkg::*;
    localparam int       PWRUP_T  = 4;
    localparam int       MON_T    = 8;
    localparam rsc_src_s SRC_IDLE = 8'h20;
    logic        clk_i = 1'b0;
    logic        srst_i, wr_i, rd_i, sleep_entered_i, idle_entered_i;
    logic [3:0]  addr_i;
    logic [15:0] wdata_i, rdata_o;
    rsc_src_s    src_i;
    rsc_fuse_s   fuse_i;
    logic [2:0]  cur_sel, cur_field, osc_select_o;
    logic        startup_done, tick, pll_lock, system_reset_out_o, osc_enable_o;
    logic        clock_ready_o, cpu_run_o, monitor_enable_o, watchdog_enable_o;
    logic        regulator_sleep_keep_o;
    logic [23:0] fetch_addr_o;
    int          bad_count = 0;
    int          total_checks = 0;
    int          tick_cnt = 0;

    reset_source_combiner #(.PWRUP_STEP_CYCLES(PWRUP_T), .MON_DLY_CYCLES(MON_T))
        u_reset_source_combiner (
        .clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .src_i(src_i), .sleep_entered_i(sleep_entered_i),
        .idle_entered_i(idle_entered_i), .fuse_i(fuse_i), .current_osc_field_i(cur_field),
        .osc_startup_done_i(startup_done), .osc_tick_i(tick), .pll_lock_i(pll_lock),
        .system_reset_out_o(system_reset_out_o), .osc_select_o(osc_select_o),
        .osc_enable_o(osc_enable_o), .clock_ready_o(clock_ready_o), .cpu_run_o(cpu_run_o),
        .fetch_addr_o(fetch_addr_o), .monitor_enable_o(monitor_enable_o),
        .watchdog_enable_o(watchdog_enable_o), .regulator_sleep_keep_o(regulator_sleep_keep_o));

    rsc_osc_model u_rsc_osc_model (
        .clk_i(clk_i), .osc_enable_i(osc_enable_o), .osc_select_i(osc_select_o),
        .running_sel_i(cur_sel), .startup_done_o(startup_done), .tick_o(tick),
        .pll_lock_o(pll_lock), .current_osc_field_o(cur_field));

    always #2.5 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        tick_cnt <= system_reset_out_o ? 0 : tick_cnt + int'(tick);
    end

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1 d = rdata_o;
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            #1 n++;
        end while (!clock_ready_o && n < 5000);
        check(clock_ready_o, 1'b1);
    endtask

    task automatic test_regs();
        logic [15:0] d;
        rd(4'h0, d);
        check(d, STATUS_RESET);
        wr(4'h0, 16'hFFFF);
        rd(4'h0, d);
        check(d, 16'hC3FF);
        check(system_reset_out_o, 1'b0);
        check({regulator_sleep_keep_o, watchdog_enable_o}, 2'h3);
        wr(4'h0, 16'h0000);
        rd(4'h5, d);
        check(d, 16'h0000);
        wr(4'h5, 16'hFFFF);
        rd(4'h0, d);
        check(d, 16'h0000);
        check({regulator_sleep_keep_o, watchdog_enable_o}, 2'h0);
        @(posedge clk_i);
        fuse_i.watchdog_fuse_enable <= 1'b1;
        sleep_entered_i <= 1'b1;
        idle_entered_i  <= 1'b1;
        #1 check(watchdog_enable_o, 1'b1);
        @(posedge clk_i);
        fuse_i.watchdog_fuse_enable <= 1'b0;
        sleep_entered_i <= 1'b0;
        idle_entered_i  <= 1'b0;
        rd(4'h0, d);
        check(d, 16'h000C);
        check(system_reset_out_o, 1'b0);
        $display("test registers done");
    endtask

    task automatic test_warm();
        int          k_tab[6] = '{5, 4, 3, 2, 1, 0};
        int          b_tab[6] = '{B_PIN, B_SOFT, B_WDOG_TO, B_MISMATCH, B_TRAP, B_ILL};
        logic [15:0] d;
        for (int i = 0; i < 6; i++) begin
            wr(4'h0, 16'h0000);
            @(posedge clk_i);
            src_i <= SRC_IDLE ^ (8'h01 << k_tab[i]);
            #1 check({system_reset_out_o, cpu_run_o}, 2'h2);
            @(posedge clk_i);
            src_i <= SRC_IDLE;
            wait_ready();
            check(osc_select_o, cur_sel);
            check(fetch_addr_o, RESET_VECTOR);
            rd(4'h0, d);
            check(d, 16'h0001 << b_tab[i]);
        end
        $display("test warm sources done");
    endtask

    task automatic test_cold(input logic [2:0] m);
        int          n;
        int          pw;
        logic [15:0] d;
        n  = 0;
        pw = (m == 3'h0) ? 0 : PWRUP_T << (m - 1);
        wr(4'h0, 16'h00F0);
        fuse_i.initial_osc_select_fuse <= m;
        fuse_i.powerup_delay_select    <= m;
        @(posedge clk_i);
        if (m[0]) begin
            src_i.brownout_active <= 1'b1;
        end else begin
            src_i.por_active <= 1'b1;
        end
        #1 check(system_reset_out_o, 1'b1);
        @(posedge clk_i);
        src_i <= SRC_IDLE;
        #1 check(osc_enable_o, 1'b0);
        while (system_reset_out_o && n < 400) begin
            @(posedge clk_i);
            #1 n++;
        end
        check(n, pw + 2);
        wait_ready();
        check(osc_select_o, m);
        if (m inside {3'h2, 3'h3, 3'h5}) check(tick_cnt >= OST_TICKS, 1'b1);
        if (m inside {3'h1, 3'h5, 3'h6}) check(pll_lock, 1'b1);
        check({cpu_run_o, fetch_addr_o}, {1'b1, RESET_VECTOR});
        n = 0;
        while (!monitor_enable_o && n < 100) begin
            @(posedge clk_i);
            #1 n++;
        end
        check(n, MON_T + 1);
        rd(4'h0, d);
        check(d, m[0] ? 16'h00F2 : STATUS_RESET);
        $display("test cold mode %0d done", m);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        bad_count++;
        report_and_stop();
    end

    initial begin
        srst_i          = 1'b1;
        addr_i          = 4'h0;
        wdata_i         = 16'h0000;
        wr_i            = 1'b0;
        rd_i            = 1'b0;
        src_i           = SRC_IDLE;
        sleep_entered_i = 1'b0;
        idle_entered_i  = 1'b0;
        fuse_i          = 8'h01;
        cur_sel         = 3'h7;
        repeat (20) @(posedge clk_i);
        srst_i <= 1'b0;
        wait_ready();
        test_regs();
        test_warm();
        for (int m = 0; m < 8; m++) begin
            test_cold(3'(m));
        end
        report_and_stop();
    end
endmodule // test_reset_source_combiner
